// ---- verilog/ccrs_defines.vh ----
// constants for the control channel register sync block
// assumes a byte register port and a single 25 mhz system clock
//
// Contract
// - three update registers at 0x5b, 0x3e, 0x4b
// - group values buffered until update register written
// - writing 0x01 starts sending that group
// - success clears update register to 0x00
// - update register reads 0x01 while busy
// - failed transfer reads 0x02
// - idle group accepts host writes
// - receiver status excludes operating mode register (here 0x43 is also the last receiver buffer slot, sent in its frame)
`ifndef CCRS_DEFINES_VH
`define CCRS_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CCRS_ADDR_LINK_STATE 8'h3e
`define CCRS_ADDR_RX_STATE 8'h4b
`define CCRS_ADDR_AUDIO_STATE 8'h5b
`define CCRS_ADDR_AUDIO_FMT 8'h50
`define CCRS_ADDR_LATENCY 8'h51
`define CCRS_ADDR_SAI_CFG 8'h52
`define CCRS_ADDR_LINK_BASE 8'h30
`define CCRS_ADDR_RX_BASE 8'h40
`define CCRS_ADDR_RX_MODE 8'h43
`define CCRS_ADDR_INT_STAT 8'h60
`define CCRS_ADDR_INT_MASK 8'h61

// ------------------------------------------------------------
// status codes and reset values
// ------------------------------------------------------------
`define CCRS_ST_IDLE_OK 8'h00
`define CCRS_ST_BUSY 8'h01
`define CCRS_ST_IDLE_FAIL 8'h02
`define CCRS_RST_DATA 8'h00

// ------------------------------------------------------------
// timing and field positions
// ------------------------------------------------------------
`define CCRS_TIMEOUT_US 1000
`define CCRS_CLK_MHZ 25
`define CCRS_TIMEOUT_CYC (`CCRS_TIMEOUT_US * `CCRS_CLK_MHZ)
`define CCRS_INT_DONE_BIT 0
`define CCRS_INT_FAIL_BIT 1

`endif

// ---- verilog/ccrs_buf_mem.v ----
// small buffer memory holding one register group's pending values
// assumes single clock, synchronous write, registered read
`timescale 1ns/1ps
module ccrs_buf_mem #(
  parameter AW = 3,
  parameter DW = 8
) (
  input wire clk_sys_in, // system clock
  input wire we_in, // write strobe
  input wire [AW-1:0] waddr_in, // write index
  input wire [DW-1:0] wdata_in, // write data
  input wire [AW-1:0] raddr_in, // read index
  output reg [DW-1:0] rdata_out // registered read data
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // write port and registered read port
  always @(posedge clk_sys_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_q[raddr_in];
  end
endmodule // ccrs_buf_mem

// ---- verilog/ccrs_grp_ctl.v ----
// one update/status register with its transfer handshake
// assumes link side answers each start with done or fail
`timescale 1ns/1ps
`include "ccrs_defines.vh"
module ccrs_grp_ctl #(
  parameter TIMEOUT_CYC = `CCRS_TIMEOUT_CYC
) (
  input wire clk_sys_in, // system clock
  input wire sys_rst_in, // sync reset, active high
  input wire wr_in, // host write to this update register
  input wire [7:0] wdata_in, // host write data
  input wire done_in, // link reports success
  input wire fail_in, // link reports failure
  output reg [7:0] state_out, // update register value
  output reg start_out, // one cycle transfer request
  output reg done_ev_out, // one cycle success event
  output reg fail_ev_out // one cycle failure event
);
  reg [24:0] tmo_q;
  wire busy = (state_out == `CCRS_ST_BUSY);

  // status register: start, success clear, failure mark
  always @(posedge clk_sys_in) begin
    start_out <= 1'b0;
    done_ev_out <= 1'b0;
    fail_ev_out <= 1'b0;
    if (sys_rst_in) begin
      state_out <= `CCRS_ST_IDLE_OK;
      tmo_q <= 25'h0000000;
    end else if (busy) begin
      tmo_q <= tmo_q + 25'h0000001;
      if (done_in) begin
        state_out <= `CCRS_ST_IDLE_OK;
        done_ev_out <= 1'b1;
      end else if (fail_in || tmo_q >= TIMEOUT_CYC[24:0]) begin
        state_out <= `CCRS_ST_IDLE_FAIL;
        fail_ev_out <= 1'b1;
      end
    end else if (wr_in && wdata_in == `CCRS_ST_BUSY) begin
      state_out <= `CCRS_ST_BUSY;
      start_out <= 1'b1;
      tmo_q <= 25'h0000000;
    end
  end
endmodule // ccrs_grp_ctl

// ---- verilog/ccrs_top.v ----
// control channel register sync engine, transmitter side
// assumes a one-cycle strobe register port and one radio link engine
// that serialises frames: it takes a byte on tx_valid and answers each
// group frame with ack or nack.
// a frame is the group id byte followed by the group's buffered bytes in
// index order; several groups may be queued, served lowest id first.
// buffer contents survive a failed transfer, so a new start resends them.
// status reads never touch a buffer, so polling is safe during a frame.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "ccrs_defines.vh"
module ccrs_top #(
  parameter TIMEOUT_CYC = `CCRS_TIMEOUT_CYC,
  parameter LINK_N = 4,
  parameter RX_N = 4
) (
  input wire clk_sys_in, // system clock 25 mhz
  input wire sys_rst_in, // sync reset, active high
  input wire [7:0] reg_addr_in, // register address
  input wire [7:0] reg_wdata_in, // write data
  input wire reg_wr_in, // write strobe
  input wire reg_rd_in, // read strobe
  output reg [7:0] reg_rdata_out, // read data, cycle after strobe
  output reg irq_out, // interrupt, active high level
  output reg tx_valid_out, // frame byte valid
  output reg [7:0] tx_data_out, // frame byte
  output reg tx_first_out, // first byte of frame (group id)
  output reg tx_last_out, // last byte of frame
  input wire tx_ready_in, // link accepts byte
  input wire link_ack_in, // frame delivered
  input wire link_nack_in // frame lost
);
  // ------------------------------------------------------------
  // state encodings and group ids
  // ------------------------------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_READ = 4'b0010;
  localparam S_SEND = 4'b0100;
  localparam S_WAIT = 4'b1000;
  localparam G_AUD = 2'd0;
  localparam G_LNK = 2'd1;
  localparam G_RX = 2'd2;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // true when address a lies in the window base .. base+n-1
  function in_range;
    input [7:0] a;
    input [7:0] base;
    input [7:0] n;
    begin
      in_range = (a >= base) && (a < base + n);
    end
  endfunction

  // number of buffered bytes carried in a frame of group g
  function [2:0] grp_len;
    input [1:0] g;
    begin
      case (g)
        G_AUD: grp_len = 3'd3;
        G_LNK: grp_len = LINK_N[2:0];
        default: grp_len = RX_N[2:0];
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // update/status registers
  // ------------------------------------------------------------
  wire [7:0] st_aud, st_lnk, st_rx;
  wire [2:0] start, done_ev, fail_ev;
  reg [2:0] ack_q, nack_q;
  // a write to a status address reaches only its own group
  wire wr_aud = reg_wr_in && reg_addr_in == `CCRS_ADDR_AUDIO_STATE;
  wire wr_lnk = reg_wr_in && reg_addr_in == `CCRS_ADDR_LINK_STATE;
  wire wr_rx = reg_wr_in && reg_addr_in == `CCRS_ADDR_RX_STATE;

  // three update registers, one per group
  // each keeps its own answer timeout, counted from its start, so a group
  // queued behind another spends part of its allowance waiting for the
  // link; the timeout has to cover the longest queue
  ccrs_grp_ctl #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_aud (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .wr_in(wr_aud),
    .wdata_in(reg_wdata_in),
    .done_in(ack_q[0]),
    .fail_in(nack_q[0]),
    .state_out(st_aud),
    .start_out(start[0]),
    .done_ev_out(done_ev[0]),
    .fail_ev_out(fail_ev[0])
  );
  ccrs_grp_ctl #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_lnk (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .wr_in(wr_lnk),
    .wdata_in(reg_wdata_in),
    .done_in(ack_q[1]),
    .fail_in(nack_q[1]),
    .state_out(st_lnk),
    .start_out(start[1]),
    .done_ev_out(done_ev[1]),
    .fail_ev_out(fail_ev[1])
  );
  ccrs_grp_ctl #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_rx (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .wr_in(wr_rx),
    .wdata_in(reg_wdata_in),
    .done_in(ack_q[2]),
    .fail_in(nack_q[2]),
    .state_out(st_rx),
    .start_out(start[2]),
    .done_ev_out(done_ev[2]),
    .fail_ev_out(fail_ev[2])
  );

  wire bsy_aud = (st_aud == `CCRS_ST_BUSY);
  wire bsy_lnk = (st_lnk == `CCRS_ST_BUSY);
  wire bsy_rx = (st_rx == `CCRS_ST_BUSY);
  // busy flags indexed by group id
  wire [2:0] bsy_v = {bsy_rx, bsy_lnk, bsy_aud};

  // ------------------------------------------------------------
  // group buffers: writes land only while the group is idle
  // ------------------------------------------------------------
  // address windows of the three buffers and the mode register
  wire hit_aud = in_range(reg_addr_in, `CCRS_ADDR_AUDIO_FMT, 8'd3);
  wire hit_lnk = in_range(reg_addr_in, `CCRS_ADDR_LINK_BASE, LINK_N[7:0]);
  wire hit_rx = in_range(reg_addr_in, `CCRS_ADDR_RX_BASE, RX_N[7:0]);
  wire hit_mode = (reg_addr_in == `CCRS_ADDR_RX_MODE);
  wire [7:0] off_aud = reg_addr_in - `CCRS_ADDR_AUDIO_FMT;
  wire [7:0] off_lnk = reg_addr_in - `CCRS_ADDR_LINK_BASE;
  wire [7:0] off_rx = reg_addr_in - `CCRS_ADDR_RX_BASE;
  // buffer write enables, held off while busy
  wire we_aud = reg_wr_in && hit_aud && !bsy_aud;
  wire we_lnk = reg_wr_in && hit_lnk && !bsy_lnk;
  wire we_rx = reg_wr_in && hit_rx && !bsy_rx;

  // frame sender state and the buffer index it reads
  reg [3:0] fsm_q;
  reg [1:0] grp_q;
  reg [2:0] idx_q;
  reg [7:0] rx_mode_q;
  reg [2:0] ridx;
  wire [7:0] rd_aud, rd_lnk, rd_rx;
  // a host read moves only the index of the buffer that it hits, so
  // polling a status register never disturbs a frame being read out;
  // reading a busy group's buffer is the host's own fault
  wire [2:0] rsel_aud = (reg_rd_in && hit_aud) ? off_aud[2:0] : ridx;
  wire [2:0] rsel_lnk = (reg_rd_in && hit_lnk) ? off_lnk[2:0] : ridx;
  wire [2:0] rsel_rx = (reg_rd_in && hit_rx) ? off_rx[2:0] : ridx;

  ccrs_buf_mem #(.AW(3), .DW(8)) u_mem_aud (
    .clk_sys_in(clk_sys_in),
    .we_in(we_aud),
    .waddr_in(off_aud[2:0]),
    .wdata_in(reg_wdata_in),
    .raddr_in(rsel_aud),
    .rdata_out(rd_aud)
  );
  ccrs_buf_mem #(.AW(3), .DW(8)) u_mem_lnk (
    .clk_sys_in(clk_sys_in),
    .we_in(we_lnk),
    .waddr_in(off_lnk[2:0]),
    .wdata_in(reg_wdata_in),
    .raddr_in(rsel_lnk),
    .rdata_out(rd_lnk)
  );
  ccrs_buf_mem #(.AW(3), .DW(8)) u_mem_rx (
    .clk_sys_in(clk_sys_in),
    .we_in(we_rx),
    .waddr_in(off_rx[2:0]),
    .wdata_in(reg_wdata_in),
    .raddr_in(rsel_rx),
    .rdata_out(rd_rx)
  );

  // operating mode keeps its own register, yet its byte also goes out in the receiver group frame
  // its address shares the last receiver buffer slot; a read returns the
  // buffer byte, which the same write fills only while the receiver group is idle
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx_mode_q <= `CCRS_RST_DATA;
    end else if (reg_wr_in && hit_mode) begin
      rx_mode_q <= reg_wdata_in;
    end
  end

  // ------------------------------------------------------------
  // frame sender: one group at a time, lowest group first
  // ------------------------------------------------------------
  // the id byte goes out while the first buffer byte is read, and each
  // later byte spends one READ cycle on the registered memory output
  reg [2:0] pend_q;
  wire [2:0] pend_d = (pend_q | start);
  // read index steps ahead on the edge that takes a data byte, so that the
  // registered memory output holds the next byte during the READ cycle
  always @* begin
    ridx = idx_q;
    if (fsm_q == S_SEND && tx_ready_in && !tx_first_out) begin
      ridx = idx_q + 3'd1;
    end
  end

  // pending requests, serialised over the single link
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      fsm_q <= S_IDLE;
      grp_q <= G_AUD;
      idx_q <= 3'd0;
      pend_q <= 3'b000;
      ack_q <= 3'b000;
      nack_q <= 3'b000;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_first_out <= 1'b0;
      tx_last_out <= 1'b0;
    end else begin
      pend_q <= pend_d;
      ack_q <= 3'b000;
      nack_q <= 3'b000;
      case (fsm_q)
        S_IDLE: begin
          // pick the lowest pending group and open its frame
          if (pend_d != 3'b000) begin
            grp_q <= pend_d[0] ? G_AUD : (pend_d[1] ? G_LNK : G_RX);
            tx_valid_out <= 1'b1; // group id byte leads frame
            tx_first_out <= 1'b1;
            tx_last_out <= 1'b0;
            tx_data_out <= pend_d[0] ? 8'h00 : (pend_d[1] ? 8'h01 : 8'h02);
            idx_q <= 3'd0;
            fsm_q <= S_SEND;
          end
        end
        S_READ: begin
          fsm_q <= S_SEND; // memory read latency
          tx_valid_out <= 1'b1;
          tx_first_out <= 1'b0;
          tx_last_out <= (idx_q == grp_len(grp_q) - 3'd1);
          tx_data_out <= (grp_q == G_AUD) ? rd_aud :
                         (grp_q == G_LNK) ? rd_lnk : rd_rx;
        end
        S_SEND: begin
          // hold the byte until the link takes it
          if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
            if (tx_last_out) begin
              fsm_q <= S_WAIT;
            end else begin
              if (!tx_first_out) begin
                idx_q <= idx_q + 3'd1;
              end
              fsm_q <= S_READ;
            end
          end
        end
        S_WAIT: begin
          // one answer pulse closes the frame for its group
          if (link_ack_in || link_nack_in) begin
            ack_q[grp_q] <= link_ack_in;
            nack_q[grp_q] <= !link_ack_in;
            pend_q[grp_q] <= 1'b0;
            fsm_q <= S_IDLE;
          end else if (!bsy_v[grp_q]) begin
            // no answer before the group timed out: free the link
            pend_q[grp_q] <= 1'b0;
            fsm_q <= S_IDLE;
          end
        end
        default: fsm_q <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupts: sticky status, clear on read, set wins
  // ------------------------------------------------------------
  // bit 0 marks a good transfer and bit 1 a failed one, from any group;
  // the interrupt level is worked out from the next status value, so it
  // never lags the status register by a cycle
  reg [1:0] int_stat_q, int_mask_q;
  wire [1:0] int_set = {|fail_ev, |done_ev};
  wire rd_stat = reg_rd_in && reg_addr_in == `CCRS_ADDR_INT_STAT;
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      int_stat_q <= 2'b00;
      int_mask_q <= 2'b00;
      irq_out <= 1'b0;
    end else begin
      int_stat_q <= (rd_stat ? 2'b00 : int_stat_q) | int_set;
      if (reg_wr_in && reg_addr_in == `CCRS_ADDR_INT_MASK) begin
        int_mask_q <= reg_wdata_in[1:0];
      end
      irq_out <= |(((rd_stat ? 2'b00 : int_stat_q) | int_set) &
                   int_mask_q);
    end
  end

  // ------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------
  // read data is zero outside the answer cycle, so a stray sample by the
  // host never picks up a stale value
  reg [2:0] rsrc_q;
  reg [7:0] rhold_q;
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rsrc_q <= 3'd0;
      rhold_q <= 8'h00;
    end else begin
      rsrc_q <= 3'd0;
      rhold_q <= 8'h00;
      if (reg_rd_in) begin
        // buffer bytes come from the memories, all else from the hold
        if (hit_aud) begin
          rsrc_q <= 3'd1;
        end else if (hit_lnk) begin
          rsrc_q <= 3'd2;
        end else if (hit_rx) begin
          rsrc_q <= 3'd3;
        end
        case (reg_addr_in)
          `CCRS_ADDR_AUDIO_STATE: rhold_q <= st_aud;
          `CCRS_ADDR_LINK_STATE: rhold_q <= st_lnk;
          `CCRS_ADDR_RX_STATE: rhold_q <= st_rx;
          `CCRS_ADDR_RX_MODE: rhold_q <= rx_mode_q;
          `CCRS_ADDR_INT_STAT: rhold_q <= {6'h00, int_stat_q};
          `CCRS_ADDR_INT_MASK: rhold_q <= {6'h00, int_mask_q};
          default: rhold_q <= 8'h00;
        endcase
      end
    end
  end

  // memory read data is already registered; pick the source
  always @* begin
    case (rsrc_q)
      3'd1: reg_rdata_out = rd_aud;
      3'd2: reg_rdata_out = rd_lnk;
      3'd3: reg_rdata_out = rd_rx;
      default: reg_rdata_out = rhold_q;
    endcase
  end
endmodule // ccrs_top

// ---- dv/ccrs_chk.sv ----
// checker for the control channel register sync block ports
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
`include "ccrs_defines.vh"
module ccrs_chk #(
  parameter TIMEOUT_CYC = 25000,
  parameter LINK_N = 4,
  parameter RX_N = 4
) (
  input wire clk_sys_in, // clock
  input wire sys_rst_in, // reset
  input wire [7:0] reg_addr_in, // address
  input wire [7:0] reg_wdata_in, // write data
  input wire reg_wr_in, // write strobe
  input wire reg_rd_in, // read strobe
  input wire [7:0] reg_rdata_out, // read data
  input wire irq_out, // interrupt
  input wire tx_valid_out, // byte valid
  input wire [7:0] tx_data_out, // byte
  input wire tx_first_out, // first byte
  input wire tx_last_out, // last byte
  input wire tx_ready_in, // link ready
  input wire link_ack_in, // ack
  input wire link_nack_in // nack
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire is_state = reg_addr_in == `CCRS_ADDR_AUDIO_STATE ||
    reg_addr_in == `CCRS_ADDR_LINK_STATE || reg_addr_in == `CCRS_ADDR_RX_STATE;
  wire take = tx_valid_out && tx_ready_in;
  reg [7:0] id_q;
  reg [7:0] nb_q;
  // count accepted bytes of the current frame
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      id_q <= 8'h00;
      nb_q <= 8'h00;
    end else if (take) begin
      id_q <= tx_first_out ? tx_data_out : id_q;
      nb_q <= tx_first_out ? 8'h01 : nb_q + 8'h01;
    end
  end
  sequence s_start;
    reg_wr_in && is_state && reg_wdata_in == 8'h01;
  endsequence
  sequence s_read_back;
    !reg_wr_in ##1 reg_rd_in && reg_addr_in == $past(reg_addr_in, 2);
  endsequence
  a_busy_read: assert property (s_start ##1 s_read_back |=>
    reg_rdata_out == 8'h01) else $error("update register not busy");
  a_start_frame: assert property (s_start |-> ##[1:400]
    tx_valid_out && tx_first_out) else $error("no frame after start");
  a_rdata_quiet: assert property (!$past(reg_rd_in) |->
    reg_rdata_out == 8'h00) else $error("read data outside slot");
  a_reset_clears: assert property (disable iff (1'b0) sys_rst_in |=>
    !irq_out && !tx_valid_out && reg_rdata_out == 8'h00)
    else $error("outputs not cleared by reset");
  a_valid_holds: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
    else $error("frame byte dropped before accept");
  a_group_id: assert property (tx_valid_out && tx_first_out |->
    tx_data_out < 8'h03 && !tx_last_out) else $error("bad group id");
  a_last_wait: assert property (take && tx_last_out |=>
    !tx_valid_out [*3]) else $error("frame sent during answer wait");
  a_frame_len: assert property (take && tx_last_out &&
    !tx_first_out |->
    nb_q == (id_q == 8'h00 ? 8'd3 : id_q == 8'h01 ? LINK_N : RX_N))
    else $error("frame length wrong");
endmodule // ccrs_chk

bind ccrs_top ccrs_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .LINK_N(LINK_N),
  .RX_N(RX_N)) ccrs_chk_i (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
  .tx_first_out(tx_first_out), .tx_last_out(tx_last_out),
  .tx_ready_in(tx_ready_in), .link_ack_in(link_ack_in),
  .link_nack_in(link_nack_in));

// ---- dv/ccrs_link_model.sv ----
// radio link stand-in: takes frame bytes, answers ack, nack or nothing
// assumes tb sets mode (0 ack, 1 nack, 2 silent) and stall between frames
`timescale 1ns/1ps
module ccrs_link_model (
  input wire clk_sys_in, // clock
  input wire sys_rst_in, // reset
  input wire tx_valid_in, // byte valid
  input wire [7:0] tx_data_in, // byte
  input wire tx_last_in, // last byte
  input wire slow_in, // stall every other cycle
  input wire [1:0] mode_in, // answer kind
  output reg tx_ready_out, // byte taken
  output reg ack_out, // frame delivered
  output reg nack_out // frame lost
);
  reg [7:0] frame_q [0:7];
  integer cnt_q;
  reg [3:0] wait_q;
  // answers frames only, never writes the update registers
  // log bytes, answer five cycles after the last one
  always @(posedge clk_sys_in) begin
    ack_out <= 1'b0;
    nack_out <= 1'b0;
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
    if (sys_rst_in) begin
      cnt_q <= 0;
      wait_q <= 4'h0;
      tx_ready_out <= 1'b0;
    end else begin
      if (tx_valid_in && tx_ready_out) begin
        frame_q[cnt_q % 8] <= tx_data_in;
        cnt_q <= cnt_q + 1;
        if (tx_last_in) wait_q <= 4'h5;
      end
      if (wait_q == 4'h1) begin
        ack_out <= mode_in == 2'd0;
        nack_out <= mode_in == 2'd1;
      end
      if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
    end
  end
endmodule // ccrs_link_model

// ---- dv/tb.sv ----
// testbench for the control channel register sync block
// assumes short answer timeout of 50 cycles and the link model
`timescale 1ns/1ps
`include "ccrs_defines.vh"
module tb;
  reg clk_sys_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg [7:0] reg_addr_in = 8'h00;
  reg [7:0] reg_wdata_in = 8'h00;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg slow = 1'b0;
  reg [1:0] mode = 2'd0;
  wire [7:0] reg_rdata_out;
  wire [7:0] tx_data_out;
  wire irq_out, tx_valid_out, tx_first_out, tx_last_out;
  wire tx_ready_in, link_ack_in, link_nack_in;
  integer errors = 0;
  integer compares = 0;
  reg [7:0] rv;
  reg [7:0] st_a [0:2];
  reg [7:0] base [0:2];
  reg [7:0] num [0:2];
  reg [2:0] b;
  integer g;
  // ----------------------------------------
  // clock, design and link model
  // ----------------------------------------
  always #20 clk_sys_in = ~clk_sys_in;
  ccrs_top #(.TIMEOUT_CYC(50)) ccrs_top_i (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_first_out(tx_first_out),
    .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
    .link_ack_in(link_ack_in), .link_nack_in(link_nack_in));
  ccrs_link_model ccrs_link_model_i (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_last_in(tx_last_out), .slow_in(slow),
    .mode_in(mode), .tx_ready_out(tx_ready_in), .ack_out(link_ack_in),
    .nack_out(link_nack_in));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task give_verdict;
    begin
      $display("counts: %0d compares, %0d errors", compares, errors);
      if (errors == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk8(input string what, input [7:0] exp, input [7:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 rv = reg_rdata_out;
    end
  endtask
  task poll(input [7:0] a);
    integer i;
    begin
      rv = 8'h01;
      for (i = 0; i < 300 && rv === 8'h01; i = i + 1) rd(a);
    end
  endtask
  task frame_chk(input integer gg, input [7:0] seed);
    reg [7:0] k;
    reg [2:0] p;
    begin
      chk8("frame id", gg[7:0], ccrs_link_model_i.frame_q[b]);
      for (k = 0; k < num[gg]; k = k + 1) begin
        p = b + 3'd1 + k[2:0];
        chk8("frame byte", seed + k, ccrs_link_model_i.frame_q[p]);
      end
    end
  endtask
  // fill a group, start it, follow it to its end state
  task send(input integer gg, input [7:0] seed, input [7:0] fin);
    reg [7:0] k;
    begin
      b = ccrs_link_model_i.cnt_q[2:0];
      for (k = 0; k < num[gg]; k = k + 1) wr(base[gg] + k, seed + k);
      rd(base[gg]);
      chk8("buffer", seed, rv);
      chk8("held", {5'h00, b}, {5'h00, ccrs_link_model_i.cnt_q[2:0]});
      wr(st_a[gg], 8'h01);
      rd(st_a[gg]);
      chk8("busy", 8'h01, rv);
      poll(st_a[gg]);
      chk8("end state", fin, rv);
      frame_chk(gg, seed);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    begin
      for (g = 0; g < 3; g = g + 1) begin
        rd(st_a[g]);
        chk8("reset state", 8'h00, rv);
      end
      rd(8'h70);
      chk8("unmapped", 8'h00, rv);
      $display("test reset done");
    end
  endtask
  task t_ok;
    begin
      slow <= 1'b1;
      for (g = 0; g < 3; g = g + 1) send(g, 8'h10 * (g + 1), 8'h00);
      wr(`CCRS_ADDR_AUDIO_STATE, 8'h01);
      wr(`CCRS_ADDR_LINK_STATE, 8'h01);
      poll(`CCRS_ADDR_LINK_STATE);
      chk8("queued", 8'h00, rv);
      chk8("masked irq", 8'h00, {7'h00, irq_out});
      rd(`CCRS_ADDR_INT_STAT);
      chk8("done flag", 8'h01, rv);
      $display("test ok done");
    end
  endtask
  task t_fail;
    begin
      slow <= 1'b0;
      mode <= 2'd1;
      wr(`CCRS_ADDR_INT_MASK, 8'h02);
      send(0, 8'ha0, 8'h02);
      repeat (3) @(posedge clk_sys_in);
      chk8("irq raised", 8'h01, {7'h00, irq_out});
      rd(`CCRS_ADDR_INT_STAT);
      chk8("fail flag", 8'h02, rv);
      repeat (3) @(posedge clk_sys_in);
      chk8("irq cleared", 8'h00, {7'h00, irq_out});
      mode <= 2'd0;
      b = ccrs_link_model_i.cnt_q[2:0];
      wr(`CCRS_ADDR_AUDIO_STATE, 8'h01);
      poll(`CCRS_ADDR_AUDIO_STATE);
      chk8("resend", 8'h00, rv);
      frame_chk(0, 8'ha0);
      wr(`CCRS_ADDR_AUDIO_STATE, 8'h05);
      rd(`CCRS_ADDR_AUDIO_STATE);
      chk8("other value", 8'h00, rv);
      mode <= 2'd2;
      send(1, 8'hc0, 8'h02);
      $display("test fail done");
    end
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    st_a[0] = `CCRS_ADDR_AUDIO_STATE;
    st_a[1] = `CCRS_ADDR_LINK_STATE;
    st_a[2] = `CCRS_ADDR_RX_STATE;
    base[0] = `CCRS_ADDR_AUDIO_FMT;
    base[1] = `CCRS_ADDR_LINK_BASE;
    base[2] = `CCRS_ADDR_RX_BASE;
    num[0] = 8'd3;
    num[1] = 8'd4;
    num[2] = 8'd4;
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_reset;
    t_ok;
    t_fail;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors = errors + 1;
    give_verdict;
  end
endmodule // tb
